// ### stm_consts.vh
// Constants for the split 16-bit timer half: register offsets, field positions, reset values.
// Assumes a 32-bit Avalon-MM slave with word-aligned byte addresses.
`ifndef STM_CONSTS_VH
`define STM_CONSTS_VH

`define STM_ADDR_W        8
`define STM_OFF_CFG       8'h00
`define STM_OFF_MODE      8'h04
`define STM_OFF_CTL       8'h0C
`define STM_OFF_IMR       8'h18
`define STM_OFF_RIS       8'h1C
`define STM_OFF_MIS       8'h20
`define STM_OFF_ICR       8'h24
`define STM_OFF_ILR       8'h28
`define STM_OFF_MATCH     8'h30
`define STM_OFF_PRE       8'h38
`define STM_OFF_TVAL      8'h48

`define STM_MODE_MR_LSB   0
`define STM_MODE_CMR_BIT  2
`define STM_MODE_AMS_BIT  3

`define STM_CTL_EN_BIT    0
`define STM_CTL_STALL_BIT 1
`define STM_CTL_EVT_LSB   2
`define STM_CTL_OTE_BIT   5
`define STM_CTL_INV_BIT   6

`define STM_INT_TO_BIT    0
`define STM_INT_CM_BIT    1
`define STM_INT_CE_BIT    2

`define STM_MR_ONESHOT    2'h1
`define STM_MR_PERIODIC   2'h2
`define STM_MR_CAPTURE    2'h3

`define STM_EVT_RISE      2'h0
`define STM_EVT_FALL      2'h1
`define STM_EVT_BOTH      2'h3

`define STM_CFG_16BIT     3'h4
`define STM_RST_LOAD      16'hFFFF
`define STM_RST_PRE       8'h00
`define STM_RST_CTL       7'h00
`define STM_RST_MODE      4'h0

`endif

// ### stm_timer_half.v
// One 16-bit half of a general-purpose timer: one-shot, periodic, edge count, edge time and PWM.
// Assumes an Avalon-MM master on ref_clk_i and a capture pin synchronous to nothing (synchronised here).
//
// Operation
// - One-shot and periodic run a 16-bit down-counter with optional 8-bit prescaler.
// - Mode-select field chooses one-shot or periodic behaviour.
// - Enable starts count-down; the cycle after zero reloads load and prescale values.
// - One-shot clears enable at time-out; periodic keeps counting.
// - Zero sets sticky raw time-out flag; masked flag follows the mask.
// - With trigger enabled, a one-clock trigger pulse follows the zero cycle, one clock after time-out.
// - A load value written while running enters the counter next cycle.
// - Stall freezes the counter until released.
// - Prescale P decrements the counter once every P+1 clocks.
// - Capture-mode bit clear selects edge count on chosen edges.
// - Each selected edge decrements by one; the edge that would take the count to match sets match flags.
// - After match, counter reloads, enable clears, further edges ignored.
// - Edge time mode bypasses the prescaler.
// - Capture-mode bit set gives free-running edge time counter from load value.
// - Selected edge copies count to timer value and sets capture flags.
// - Captured value holds until the next selected edge.
// - Edge time keeps counting after capture, reloading at zero.
// - PWM applies with alternate bit set, capture bit clear, mode periodic.
// - PWM reloads after zero, runs until disabled, sets no flags.
// - PWM output rises at count equal load, falls at count equal match.
// - Output-level invert drives the inverse PWM waveform.
// - Mode-select encodes one-shot as 1 and periodic as 2.
// - Mode-select value 3 means capture operation.
// - Writing one to an interrupt-clear bit clears raw and masked flag.
`timescale 1ns/1ps
`include "stm_consts.vh"

module stm_timer_half #(
	parameter CNT_W = 16,
	parameter PRE_W = 8
) (
	input  wire                   ref_clk_i,
	input  wire                   rstn_i,
	input  wire [`STM_ADDR_W-1:0] avs_address_i,
	input  wire                   avs_read_i,
	input  wire                   avs_write_i,
	input  wire [31:0]            avs_writedata_i,
	input  wire [3:0]             avs_byteenable_i,
	output reg  [31:0]            avs_readdata_o,
	output reg                    avs_waitrequest_o,
	input  wire                   ccp_in_i,
	output reg                    ccp_out_o,
	output reg                    ccp_oe_o,
	output reg                    trigger_o,
	output reg                    irq_o
);

	localparam ST_IDLE = 2'b01;
	localparam ST_RESP = 2'b10;

	reg [1:0]       bus_st_r;
	reg [2:0]       cfg_r;
	reg [3:0]       mode_r;
	reg [6:0]       ctl_r;
	reg [2:0]       imr_r;
	reg [2:0]       ris_r;
	reg [CNT_W-1:0] ilr_r;
	reg [CNT_W-1:0] match_r;
	reg [PRE_W-1:0] pre_r;
	reg [CNT_W-1:0] cnt_r;
	reg [PRE_W-1:0] pcnt_r;
	reg [CNT_W-1:0] tval_r;
	reg             pwm_r;
	reg             ccp_s1_r;
	reg             ccp_s2_r;
	reg             ccp_s3_r;
	reg             ilr_wr_r;

	wire [1:0] mr        = mode_r[`STM_MODE_MR_LSB+1:`STM_MODE_MR_LSB];
	wire       cmr       = mode_r[`STM_MODE_CMR_BIT];
	wire       ams       = mode_r[`STM_MODE_AMS_BIT];
	wire       en        = ctl_r[`STM_CTL_EN_BIT];
	wire       stall     = ctl_r[`STM_CTL_STALL_BIT];
	wire [1:0] evt       = ctl_r[`STM_CTL_EVT_LSB+1:`STM_CTL_EVT_LSB];
	wire       ote       = ctl_r[`STM_CTL_OTE_BIT];
	wire       inv       = ctl_r[`STM_CTL_INV_BIT];
	wire       pwm_mode  = ams & ~cmr & (mr == `STM_MR_PERIODIC);
	wire       cap_mode  = ~ams & (mr == `STM_MR_CAPTURE);
	wire       cnt_mode  = cap_mode & ~cmr;
	wire       time_mode = cap_mode & cmr;
	wire       tmr_mode  = ~ams & ((mr == `STM_MR_ONESHOT) | (mr == `STM_MR_PERIODIC));
	wire       oneshot   = mr == `STM_MR_ONESHOT;
	wire       rise      = ccp_s2_r & ~ccp_s3_r;
	wire       fall      = ~ccp_s2_r & ccp_s3_r;

	// Edge selection: rising, falling or both.
	function edge_hit;
		input [1:0] sel;
		input       r;
		input       f;
		begin
			case (sel)
				`STM_EVT_RISE: edge_hit = r;
				`STM_EVT_FALL: edge_hit = f;
				`STM_EVT_BOTH: edge_hit = r | f;
				default:       edge_hit = r;
			endcase
		end
	endfunction

	wire sel_edge = edge_hit(evt, rise, fall);
	// Prescaler tick; bypassed in the capture modes.
	wire use_pre  = tmr_mode | pwm_mode;
	wire tick     = en & ~stall & (~use_pre | (pcnt_r == {PRE_W{1'b0}}));
	wire at_zero  = (cnt_r == {CNT_W{1'b0}});
	wire to_evt   = tmr_mode & tick & at_zero;
	wire cm_evt   = cnt_mode & en & ~stall & sel_edge & (cnt_r - 1'b1 == match_r);
	wire ce_evt   = time_mode & en & sel_edge;

	wire acc      = (avs_read_i | avs_write_i) & (bus_st_r == ST_IDLE);
	wire wr       = avs_write_i & (bus_st_r == ST_IDLE);
	wire wr_ctl   = wr & (avs_address_i == `STM_OFF_CTL) & avs_byteenable_i[0];
	wire wr_ilr   = wr & (avs_address_i == `STM_OFF_ILR) & (&avs_byteenable_i[1:0]);
	wire wr_icr   = wr & (avs_address_i == `STM_OFF_ICR) & avs_byteenable_i[0];
	wire [2:0] mis = ris_r & imr_r;

	always @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ccp_s1_r <= 1'b0;
			ccp_s2_r <= 1'b0;
			ccp_s3_r <= 1'b0;
		end else begin
			ccp_s1_r <= ccp_in_i;
			ccp_s2_r <= ccp_s1_r;
			ccp_s3_r <= ccp_s2_r;
		end
	end

	// Bus slave: one wait cycle, answer on the second.
	always @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			bus_st_r          <= ST_IDLE;
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o    <= 32'h00000000;
		end else begin
			case (bus_st_r)
				ST_IDLE: begin
					avs_waitrequest_o <= ~acc;
					if (acc) begin
						bus_st_r <= ST_RESP;
					end
					// Read data is latched only for an accepted read, so it stands until the next answer.
					if (acc & avs_read_i) case (avs_address_i)
						`STM_OFF_CFG:   avs_readdata_o <= {29'h0, cfg_r};
						`STM_OFF_MODE:  avs_readdata_o <= {28'h0, mode_r};
						`STM_OFF_CTL:   avs_readdata_o <= {25'h0, ctl_r};
						`STM_OFF_IMR:   avs_readdata_o <= {29'h0, imr_r};
						`STM_OFF_RIS:   avs_readdata_o <= {29'h0, ris_r};
						`STM_OFF_MIS:   avs_readdata_o <= {29'h0, mis};
						`STM_OFF_ILR:   avs_readdata_o <= {{(32-CNT_W){1'b0}}, ilr_r};
						`STM_OFF_MATCH: avs_readdata_o <= {{(32-CNT_W){1'b0}}, match_r};
						`STM_OFF_PRE:   avs_readdata_o <= {{(32-PRE_W){1'b0}}, pre_r};
						`STM_OFF_TVAL:  avs_readdata_o <= {{(32-CNT_W){1'b0}}, time_mode ? tval_r : cnt_r};
						default:        avs_readdata_o <= 32'h00000000;
					endcase
				end
				ST_RESP: begin
					bus_st_r          <= ST_IDLE;
					avs_waitrequest_o <= 1'b1;
				end
				default: begin
					bus_st_r          <= ST_IDLE;
					avs_waitrequest_o <= 1'b1;
				end
			endcase
		end
	end

	// Configuration registers; writes land at the accepting edge of the idle cycle.
	always @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cfg_r   <= 3'h0;
			mode_r  <= `STM_RST_MODE;
			imr_r   <= 3'h0;
			ilr_r   <= `STM_RST_LOAD;
			match_r <= {CNT_W{1'b1}};
			pre_r   <= `STM_RST_PRE;
		end else if (wr) begin
			case (avs_address_i)
				`STM_OFF_CFG:   cfg_r   <= avs_writedata_i[2:0];
				`STM_OFF_MODE:  mode_r  <= avs_writedata_i[3:0];
				`STM_OFF_IMR:   imr_r   <= avs_writedata_i[2:0];
				`STM_OFF_ILR:   ilr_r   <= avs_writedata_i[CNT_W-1:0];
				`STM_OFF_MATCH: match_r <= avs_writedata_i[CNT_W-1:0];
				`STM_OFF_PRE:   pre_r   <= avs_writedata_i[PRE_W-1:0];
				default:        cfg_r   <= cfg_r;
			endcase
		end
	end

	// Control register; hardware clears enable on one-shot time-out and count match.
	always @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ctl_r <= `STM_RST_CTL;
		end else begin
			if (wr_ctl) begin
				ctl_r <= avs_writedata_i[6:0];
			end
			if ((to_evt & oneshot) | cm_evt) begin
				ctl_r[`STM_CTL_EN_BIT] <= 1'b0;
			end
		end
	end

	// Sticky status: a set in the same cycle as a clear wins.
	always @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ris_r <= 3'h0;
		end else begin
			ris_r <= (ris_r & ~(wr_icr ? avs_writedata_i[2:0] : 3'h0))
				| {ce_evt, cm_evt, to_evt};
		end
	end

	// Counter, prescaler and capture.
	always @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_r    <= `STM_RST_LOAD;
			pcnt_r   <= `STM_RST_PRE;
			tval_r   <= `STM_RST_LOAD;
			ilr_wr_r <= 1'b0;
		end else begin
			ilr_wr_r <= wr_ilr;
			if (ce_evt) begin
				tval_r <= cnt_r;
			end
			if (ilr_wr_r) begin
				cnt_r  <= ilr_r;
				pcnt_r <= pre_r;
			end else if (cm_evt) begin
				cnt_r <= ilr_r;
			end else if (cnt_mode) begin
				if (en & ~stall & sel_edge) begin
					cnt_r <= cnt_r - 1'b1;
				end
			end else if (en & ~stall) begin
				if (use_pre & (pcnt_r != {PRE_W{1'b0}})) begin
					pcnt_r <= pcnt_r - 1'b1;
				end else if (at_zero) begin
					cnt_r  <= ilr_r;
					pcnt_r <= pre_r;
				end else begin
					cnt_r  <= cnt_r - 1'b1;
					pcnt_r <= pre_r;
				end
			end
		end
	end

	// Outputs: trigger, interrupt and PWM pin.
	always @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			trigger_o <= 1'b0;
			irq_o     <= 1'b0;
			pwm_r     <= 1'b0;
			ccp_out_o <= 1'b0;
			ccp_oe_o  <= 1'b0;
		end else begin
			trigger_o <= ote & to_evt;
			irq_o     <= |(((ris_r & ~(wr_icr ? avs_writedata_i[2:0] : 3'h0))
				| {ce_evt, cm_evt, to_evt}) & imr_r);
			if (pwm_mode & en) begin
				if (cnt_r == ilr_r) begin
					pwm_r <= 1'b1;
				end else if (cnt_r == match_r) begin
					pwm_r <= 1'b0;
				end
			end
			ccp_out_o <= (pwm_mode & en) ? (pwm_r ^ inv) : 1'b0;
			ccp_oe_o  <= pwm_mode & en;
		end
	end

endmodule // stm_timer_half

// ### stm_pin_model.sv
// Capture pin driver: after go, toggles the pin a given number of times, five clocks apart.
// Assumes one clock shared with the timer half.
`timescale 1ns/1ps
module stm_pin_model (
	input  wire       ref_clk_i,
	input  wire       go_i,
	input  wire [3:0] edges_i,
	output reg        pin_o,
	output reg        busy_o
);
	reg [3:0] left_r;
	reg [2:0] gap_r;
	initial begin
		pin_o = 1'b0;
		busy_o = 1'b0;
	end
	always @(posedge ref_clk_i) begin
		if (go_i) begin
			left_r <= edges_i;
			gap_r <= 3'h4;
			busy_o <= 1'b1;
		end else if (busy_o) begin
			gap_r <= gap_r - 3'h1;
			if (gap_r == 3'h0) begin
				pin_o <= !pin_o;
				left_r <= left_r - 4'h1;
				gap_r <= 3'h4;
				busy_o <= (left_r != 4'h1);
			end
		end
	end
endmodule // stm_pin_model

// ### stm_timer_half_asserts.sv
// Port checker for the timer half: bus answer shape, trigger pulse, pin drive.
// Assumes binding onto stm_timer_half.
`timescale 1ns/1ps
module stm_timer_half_asserts (
	input wire        ref_clk_i,
	input wire        rstn_i,
	input wire        avs_read_i,
	input wire        avs_write_i,
	input wire [31:0] avs_readdata_o,
	input wire        avs_waitrequest_o,
	input wire        ccp_out_o,
	input wire        ccp_oe_o,
	input wire        trigger_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);
	sequence s_req;
		(avs_read_i || avs_write_i) && avs_waitrequest_o;
	endsequence
	sequence s_ans;
		!avs_waitrequest_o ##1 avs_waitrequest_o;
	endsequence
	a_bus_answer: assert property (s_req |=> s_ans) else $error("bus answer late");
	a_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o) else $error("wait low too long");
	a_wait_cause: assert property (!avs_waitrequest_o |-> $past(avs_read_i || avs_write_i)) else $error("answer unasked");
	a_idle_wait: assert property (!(avs_read_i || avs_write_i) |=> avs_waitrequest_o) else $error("idle answer");
	a_rdata_hold: assert property (!$fell(avs_waitrequest_o) |-> $stable(avs_readdata_o)) else $error("data moved");
	a_trig_pulse: assert property (trigger_o |=> !trigger_o) else $error("trigger too wide");
	a_pin_idle: assert property (!ccp_oe_o |-> !ccp_out_o) else $error("pin driven idle");
	a_oe_cause: assert property ($changed(ccp_oe_o) |-> $past(avs_write_i) || $past(avs_write_i, 2))
		else $error("drive changed unasked");
endmodule // stm_timer_half_asserts

// ### stm_timer_half_tb_top.sv
// Self-checking bench for the timer half over Avalon-MM.
// Assumes the pin model drives the capture input.
`timescale 1ns/1ps
`include "stm_consts.vh"
module stm_timer_half_tb_top;
	reg         clk, rstn, rd, wr, go;
	reg  [7:0]  adr;
	reg  [31:0] wd, q;
	reg  [3:0]  ne;
	wire [31:0] rdat;
	wire        wreq, pin, pout, poe, trig, irq, busy;
	integer     err_count, checks_done, cyc;
	stm_timer_half stm_timer_half_i (.ref_clk_i(clk), .rstn_i(rstn), .avs_address_i(adr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
		.avs_waitrequest_o(wreq), .ccp_in_i(pin), .ccp_out_o(pout), .ccp_oe_o(poe), .trigger_o(trig), .irq_o(irq));
	stm_pin_model stm_pin_model_i (.ref_clk_i(clk), .go_i(go), .edges_i(ne), .pin_o(pin), .busy_o(busy));
	initial begin
		clk = 1'b0;
		forever #50 clk = !clk;
	end
	always @(posedge clk) cyc <= cyc + 1;
	task give_verdict;
		begin
			if (err_count == 0 && checks_done > 0) $display("Run complete: PASS");
			else $display("Run complete: FAIL");
			$finish;
		end
	endtask
	task hang;
		begin
			err_count = err_count + 1;
			give_verdict;
		end
	endtask
	task cmp(input [31:0] got, input [31:0] exp);
		begin
			checks_done = checks_done + 1;
			if (got !== exp) begin
				err_count = err_count + 1;
				$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task bus(input w, input [7:0] a, input [31:0] d);
		integer k;
		begin
			adr <= a;
			wd <= d;
			wr <= w;
			rd <= !w;
			k = 0;
			@(posedge clk);
			while (wreq !== 1'b0) begin
				k = k + 1;
				if (k > 50) hang;
				@(posedge clk);
			end
			q = rdat;
			wr <= 1'b0;
			rd <= 1'b0;
			@(posedge clk);
		end
	endtask
	task wtrig(output integer t);
		integer k;
		begin
			k = 0;
			@(negedge clk);
			while (trig !== 1'b1) begin
				k = k + 1;
				if (k > 300) hang;
				@(negedge clk);
			end
			t = cyc;
			@(posedge clk);
		end
	endtask
	task cnt(input integer c, input s, output integer n);
		begin
			n = 0;
			repeat (c) begin
				@(negedge clk);
				n = n + ((s ? pout : trig) === 1'b1);
			end
			@(posedge clk);
		end
	endtask
	task edges(input [3:0] e);
		integer k;
		begin
			ne <= e;
			go <= 1'b1;
			@(posedge clk);
			go <= 1'b0;
			k = 0;
			@(posedge clk);
			while (busy !== 1'b0 && k < 100) begin
				k = k + 1;
				@(posedge clk);
			end
			if (k == 100) hang;
			// The last pin edge reaches the counter three clocks after the toggle.
			repeat (4) @(posedge clk);
		end
	endtask
	task t_reset;
		begin
			bus(0, `STM_OFF_ILR, 0);
			cmp(q, 32'h0000FFFF);
			bus(0, `STM_OFF_PRE, 0);
			cmp(q, 32'h0);
			bus(0, 8'h7C, 0);
			cmp(q, 32'h0);
		end
	endtask
	task t_periodic;
		integer a, b, n;
		begin
			bus(1, `STM_OFF_CFG, 32'h4);
			bus(1, `STM_OFF_MODE, 32'h2);
			bus(1, `STM_OFF_PRE, 32'h1);
			bus(1, `STM_OFF_ILR, 32'h3);
			bus(1, `STM_OFF_IMR, 32'h1);
			bus(1, `STM_OFF_CTL, 32'h21);
			wtrig(a);
			wtrig(b);
			cmp(b - a, 8);
			cmp({31'h0, irq}, 32'h1);
			bus(1, `STM_OFF_CTL, 32'h23);
			cnt(30, 0, n);
			cmp(n, 0);
			bus(1, `STM_OFF_ICR, 32'h1);
			bus(0, `STM_OFF_RIS, 0);
			cmp(q, 32'h0);
			cmp({31'h0, irq}, 32'h0);
			bus(1, `STM_OFF_CTL, 32'h0);
		end
	endtask
	task t_oneshot;
		integer s, a, n;
		begin
			bus(1, `STM_OFF_MODE, 32'h1);
			bus(1, `STM_OFF_PRE, 32'h0);
			bus(1, `STM_OFF_ILR, 32'd200);
			bus(1, `STM_OFF_CTL, 32'h21);
			s = cyc;
			bus(1, `STM_OFF_ILR, 32'h5);
			wtrig(a);
			cmp(a - s < 20, 1);
			bus(0, `STM_OFF_CTL, 0);
			cmp(q[0], 0);
			bus(0, `STM_OFF_RIS, 0);
			cmp(q, 32'h1);
			cnt(30, 0, n);
			cmp(n, 0);
		end
	endtask
	task t_edgecnt;
		begin
			bus(1, `STM_OFF_ICR, 32'h7);
			bus(1, `STM_OFF_MODE, 32'h3);
			bus(1, `STM_OFF_ILR, 32'hA);
			bus(1, `STM_OFF_MATCH, 32'h6);
			bus(1, `STM_OFF_CTL, 32'hD);
			edges(4'h6);
			bus(0, `STM_OFF_RIS, 0);
			cmp(q, 32'h2);
			bus(0, `STM_OFF_CTL, 0);
			cmp(q[0], 0);
			bus(0, `STM_OFF_TVAL, 0);
			cmp(q[15:0], 16'hA);
		end
	endtask
	task t_edgetime;
		reg [31:0] a;
		begin
			bus(1, `STM_OFF_ICR, 32'h7);
			bus(1, `STM_OFF_MODE, 32'h7);
			bus(1, `STM_OFF_ILR, 32'hFFFF);
			bus(1, `STM_OFF_PRE, 32'hFF);
			bus(1, `STM_OFF_CTL, 32'h1);
			edges(4'h2);
			bus(0, `STM_OFF_TVAL, 0);
			a = q;
			cmp(a[15:0] > 16'hFF00, 1);
			bus(0, `STM_OFF_RIS, 0);
			cmp(q, 32'h4);
			bus(0, `STM_OFF_TVAL, 0);
			cmp(q, a);
			bus(1, `STM_OFF_CTL, 32'h0);
		end
	endtask
	task t_pwm(input inv);
		integer n;
		begin
			bus(1, `STM_OFF_ICR, 32'h7);
			bus(1, `STM_OFF_PRE, 32'h0);
			bus(1, `STM_OFF_MODE, 32'hA);
			bus(1, `STM_OFF_ILR, 32'h9);
			bus(1, `STM_OFF_MATCH, 32'h3);
			bus(1, `STM_OFF_CTL, {25'h0, inv, 6'h1});
			cnt(12, 1, n);
			cmp({31'h0, poe}, 32'h1);
			cnt(20, 1, n);
			cmp(n, inv ? 8 : 12);
			bus(0, `STM_OFF_RIS, 0);
			cmp(q, 32'h0);
			bus(1, `STM_OFF_CTL, 32'h0);
		end
	endtask
	initial begin
		rstn = 1'b0;
		rd = 1'b0;
		wr = 1'b0;
		go = 1'b0;
		adr = 8'h00;
		wd = 32'h0;
		ne = 4'h0;
		cyc = 0;
		err_count = 0;
		checks_done = 0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		t_reset;
		t_periodic;
		t_oneshot;
		t_edgecnt;
		t_edgetime;
		t_pwm(1'b0);
		t_pwm(1'b1);
		give_verdict;
	end
endmodule // stm_timer_half_tb_top
bind stm_timer_half stm_timer_half_asserts stm_timer_half_asserts_i (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
	.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
	.avs_waitrequest_o(avs_waitrequest_o), .ccp_out_o(ccp_out_o), .ccp_oe_o(ccp_oe_o), .trigger_o(trigger_o));
